// File: pmucr_top.sv
// Comparator, status and interrupt register bank behind the serial port
`timescale 1ns/100ps
module pmucr_top
    import pmucr_pkg::*;
(
    input wire logic REF_CLK,
    input wire logic RST,
    input wire logic SPI_CLK,
    input wire logic SPI_CS_N,
    input wire logic SPI_DI,
    output logic SPI_DO,
    input wire logic COMP_OUT,
    input wire logic BUCK1_OK,
    input wire logic BUCK2_OK,
    input wire logic BUCK3_OK,
    input wire logic LINEAR_OK,
    input wire logic [5:0] BUCK1_CODE,
    input wire logic [5:0] BUCK2_CODE,
    output logic COMP_ON,
    output logic [5:0] COMP_THR_CODE,
    output logic [11:0] COMP_THR_MV,
    output logic [6:0] COMP_HYST_MV,
    output logic LINEAR_REG_DEEP_SAVE,
    output logic INT_OUT,
    output logic [11:0] BUCK1_MV,
    output logic [11:0] BUCK2_MV
);

    // ----------------------------------------
    // Types
    // ----------------------------------------
    typedef struct packed {
        logic [4:0] cnt;
        logic [7:0] sh;
        logic [1:0] cmd;
        logic [4:0] addr;
        logic [7:0] rd;
        logic dout;
    } pmucr_frame_t;

    typedef struct packed {
        logic [7:0] comp;
        logic [IEN_W-1:0] ien;
        logic [MISC_W-1:0] misc;
    } pmucr_lreg_t;

    localparam int CFG_W = 8 + IEN_W + MISC_W;
    localparam logic [CFG_W-1:0] CFG_RST = {COMP_RST, IEN_RST, MISC_RST};

    typedef struct packed {
        logic [CFG_W-1:0] cfg_seen;
        logic [CFG_W-1:0] cfg_used;
        logic comp_on;
        logic [5:0] thr_code;
        logic [11:0] thr_mv;
        logic [6:0] hyst_mv;
        logic deep;
        logic irq;
    } pmucr_core_t;

    // Reset image; interrupt idles at the inactive level of the reset polarity
    localparam pmucr_core_t CO_RST = '{
        cfg_seen: CFG_RST,
        cfg_used: CFG_RST,
        comp_on: COMP_RST[COMP_EN_BIT],
        thr_code: COMP_RST[COMP_THR_MSB:COMP_THR_LSB],
        thr_mv: thr_mv(COMP_RST[COMP_THR_MSB:COMP_THR_LSB]),
        hyst_mv: HYST_NORM_MV,
        deep: MISC_RST[MISC_SAVE_BIT],
        irq: ~MISC_RST[MISC_POL_BIT]
    };

    // ----------------------------------------
    // Signals
    // ----------------------------------------
    pmucr_frame_t fr_q;
    pmucr_frame_t fr_d;
    pmucr_lreg_t lr_q;
    pmucr_lreg_t lr_d;
    pmucr_core_t co_q;
    pmucr_core_t co_d;

    logic frame_rst;
    logic [4:0] stat_pins;
    logic [4:0] stat_link;
    logic [4:0] stat_core;
    logic [CFG_W-1:0] cfg_core;
    logic [7:0] comp_c;
    logic [IEN_W-1:0] ien_c;
    logic [MISC_W-1:0] misc_c;
    logic [4:0] addr_now;
    logic [7:0] rd_word;
    logic [7:0] wr_word;
    logic pending;
    logic [3:0] sel_rd;
    logic [3:0] sel_wr;
    logic [CFG_W-1:0] cfg_take;

    // ----------------------------------------
    // Functions
    // ----------------------------------------
    // Register select, shared by the read view and the write strobe
    function automatic logic [3:0] reg_sel(input logic [4:0] a);
        logic [3:0] sel;
        sel = 4'h0;
        unique case (a)
            ADDR_COMP: sel = 4'h1;
            ADDR_IEN: sel = 4'h2;
            ADDR_STAT: sel = 4'h4;
            ADDR_MISC: sel = 4'h8;
            default: sel = 4'h0;
        endcase
        return sel;
    endfunction

    // Live levels, no latching of events
    assign stat_pins = {LINEAR_OK, BUCK3_OK, BUCK2_OK, BUCK1_OK, COMP_OUT};

    // ----------------------------------------
    // Link domain: serial frame
    // ----------------------------------------
    // Frame state ends with the select itself, as the link clock stops
    assign frame_rst = RST | SPI_CS_N;

    assign addr_now = {fr_q.sh[3:0], SPI_DI};
    assign wr_word = {fr_q.sh[6:0], SPI_DI};
    assign sel_rd = reg_sel(addr_now);
    assign sel_wr = reg_sel(fr_q.addr);

    // ----------------------------------------
    // Read view
    // ----------------------------------------
    // Unused and reserved bits read zero
    always_comb begin
        rd_word = 8'h00;
        if (sel_rd[0]) begin
            rd_word = lr_q.comp;
        end
        if (sel_rd[1]) begin
            rd_word = {3'h0, lr_q.ien};
        end
        if (sel_rd[2]) begin
            rd_word = {3'h0, stat_link};
        end
        if (sel_rd[3]) begin
            rd_word = {6'h00, lr_q.misc};
        end
    end

    always_comb begin
        fr_d = fr_q;
        lr_d = lr_q;
        // Count saturates so a long frame cannot wrap into a second command
        if (fr_q.cnt != CNT_END) begin
            fr_d.cnt = fr_q.cnt + 5'h01;
        end
        fr_d.sh = {fr_q.sh[6:0], SPI_DI};
        fr_d.rd = {fr_q.rd[6:0], 1'b0};
        fr_d.dout = 1'b0;
        if (fr_q.cnt == CNT_CMD_LAST) begin
            fr_d.cmd = {fr_q.sh[0], SPI_DI};
        end
        if (fr_q.cnt == CNT_ADDR_LAST) begin
            fr_d.addr = addr_now;
            if (fr_q.cmd == CMD_READ) begin
                fr_d.dout = rd_word[7];
                fr_d.rd = {rd_word[6:0], 1'b0};
            end
        end else if (fr_q.cnt > CNT_ADDR_LAST) begin
            // Input after the address is ignored on reads
            fr_d.dout = fr_q.rd[7];
        end
        if (fr_q.cnt == CNT_DATA_LAST && fr_q.cmd == CMD_WRITE) begin
            // Status and unmapped addresses fall through untouched
            if (sel_wr[0]) begin
                lr_d.comp = wr_word;
            end
            if (sel_wr[1]) begin
                lr_d.ien = wr_word[IEN_W-1:0];
            end
            if (sel_wr[3]) begin
                lr_d.misc = wr_word[MISC_W-1:0];
            end
        end
    end

    always_ff @(posedge SPI_CLK or posedge frame_rst) begin
        if (frame_rst) begin
            fr_q <= '0;
        end else begin
            fr_q <= fr_d;
        end
    end

    always_ff @(posedge SPI_CLK or posedge RST) begin
        if (RST) begin
            lr_q <= '{comp: COMP_RST, ien: IEN_RST, misc: MISC_RST};
        end else begin
            lr_q <= lr_d;
        end
    end

    assign SPI_DO = fr_q.dout;

    // Status pins into the link clock; six edges pass before a read loads
    pmucr_sync #(.W(5), .RV(5'h00)) u_stat_link (
        .clk(SPI_CLK),
        .rst(RST),
        .d(stat_pins),
        .q(stat_link)
    );

    // ----------------------------------------
    // Core domain
    // ----------------------------------------
    // Settings cross bit by bit; a word counts only once two samples agree,
    // so a write caught in flight never shows as a mixed code
    pmucr_sync #(.W(CFG_W), .RV(CFG_RST)) u_cfg_core (
        .clk(REF_CLK),
        .rst(RST),
        .d({lr_q.comp, lr_q.ien, lr_q.misc}),
        .q(cfg_core)
    );

    pmucr_sync #(.W(5), .RV(5'h00)) u_stat_core (
        .clk(REF_CLK),
        .rst(RST),
        .d(stat_pins),
        .q(stat_core)
    );


    // ----------------------------------------
    // Configuration handover
    // ----------------------------------------
    // Costs one core cycle of latency against a torn word
    // after a write
    assign cfg_take = (cfg_core == co_q.cfg_seen) ? cfg_core : co_q.cfg_used;
    assign comp_c = cfg_take[CFG_W-1 -: 8];
    assign ien_c = cfg_take[IEN_W+MISC_W-1 -: IEN_W];
    assign misc_c = cfg_take[MISC_W-1:0];
    assign pending = |(stat_core & ien_c);

    always_comb begin
        co_d = co_q;
        co_d.cfg_seen = cfg_core;
        co_d.cfg_used = cfg_take;
        co_d.comp_on = comp_c[COMP_EN_BIT];
        co_d.thr_code = comp_c[COMP_THR_MSB:COMP_THR_LSB];
        co_d.thr_mv = thr_mv(comp_c[COMP_THR_MSB:COMP_THR_LSB]);
        co_d.hyst_mv = comp_c[COMP_HYST_BIT] ? HYST_DBL_MV : HYST_NORM_MV;
        co_d.deep = misc_c[MISC_SAVE_BIT];
        // Polarity 0 drives low when active
        co_d.irq = misc_c[MISC_POL_BIT] ? pending : ~pending;
    end

    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            co_q <= CO_RST;
        end else begin
            co_q <= co_d;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign COMP_ON = co_q.comp_on;
    assign COMP_THR_CODE = co_q.thr_code;
    assign COMP_THR_MV = co_q.thr_mv;
    assign COMP_HYST_MV = co_q.hyst_mv;
    assign LINEAR_REG_DEEP_SAVE = co_q.deep;
    assign INT_OUT = co_q.irq;

    // ----------------------------------------
    // Buck voltage targets
    // ----------------------------------------
    pmucr_vmap u_buck1 (
        .clk(REF_CLK),
        .rst(RST),
        .code(BUCK1_CODE),
        .mv(BUCK1_MV)
    );

    pmucr_vmap u_buck2 (
        .clk(REF_CLK),
        .rst(RST),
        .code(BUCK2_CODE),
        .mv(BUCK2_MV)
    );

endmodule

// File: pmucr_pkg.sv
// Package: register map, field layout, reset values and voltage mapping
package pmucr_pkg;

    // ----------------------------------------
    // Register offsets
    // ----------------------------------------
    localparam logic [4:0] ADDR_COMP = 5'h0B;
    localparam logic [4:0] ADDR_IEN = 5'h0C;
    localparam logic [4:0] ADDR_STAT = 5'h0D;
    localparam logic [4:0] ADDR_MISC = 5'h0E;

    // ----------------------------------------
    // Field positions
    // ----------------------------------------
    localparam int COMP_EN_BIT = 0;
    localparam int COMP_THR_LSB = 1;
    localparam int COMP_THR_MSB = 6;
    localparam int COMP_HYST_BIT = 7;
    localparam int MISC_POL_BIT = 0;
    localparam int MISC_SAVE_BIT = 1;
    localparam int IEN_W = 5;
    localparam int MISC_W = 2;

    // ----------------------------------------
    // Reset values
    // ----------------------------------------
    localparam logic [7:0] COMP_RST = 8'h33;
    localparam logic [4:0] IEN_RST = 5'h01;
    localparam logic [1:0] MISC_RST = 2'h0;

    // ----------------------------------------
    // Serial frame
    // ----------------------------------------
    localparam logic [1:0] CMD_WRITE = 2'h2;
    localparam logic [1:0] CMD_READ = 2'h3;
    localparam logic [4:0] CNT_CMD_LAST = 5'h01;
    localparam logic [4:0] CNT_ADDR_LAST = 5'h06;
    localparam logic [4:0] CNT_DATA_LAST = 5'h0E;
    localparam logic [4:0] CNT_END = 5'h1F;

    // ----------------------------------------
    // Voltage mapping, millivolts
    // ----------------------------------------
    localparam int THR_BASE_MV = 2000;
    localparam int THR_SPAN_MV = 2000;
    localparam int THR_TOP_CODE = 63;
    localparam int BUCK_BASE_MV = 1100;
    localparam int BUCK_STEP_MV = 50;
    localparam logic [5:0] BUCK_TOP_CODE = 6'h32;
    localparam logic [6:0] HYST_NORM_MV = 7'h28;
    localparam logic [6:0] HYST_DBL_MV = 7'h50;

    // Rounded linear map, code 0 to 2.0 V, top code to 4.0 V
    function automatic logic [11:0] thr_mv(input logic [5:0] code);
        logic [17:0] prod;
        prod = 18'(code) * 18'(THR_SPAN_MV) + 18'(THR_TOP_CODE / 2);
        return 12'(18'(THR_BASE_MV) + prod / 18'(THR_TOP_CODE));
    endfunction

    // Saturates above the top code
    function automatic logic [11:0] buck_mv(input logic [5:0] code);
        logic [5:0] sat;
        sat = (code > BUCK_TOP_CODE) ? BUCK_TOP_CODE : code;
        return 12'(BUCK_BASE_MV) + 12'(sat) * 12'(BUCK_STEP_MV);
    endfunction

endpackage

// File: pmucr_sync.sv
// Two-flop level synchroniser with a chosen reset value
`timescale 1ns/100ps
module pmucr_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] RV = '0
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } pmucr_sync_t;

    pmucr_sync_t st_q;
    pmucr_sync_t st_d;

    // First stage feeds only the second
    always_comb begin
        st_d.s1 = d;
        st_d.s2 = st_q.s1;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st_q <= '{s1: RV, s2: RV};
        end else begin
            st_q <= st_d;
        end
    end

    assign q = st_q.s2;
endmodule

// File: pmucr_vmap.sv
// Buck voltage code to registered millivolt target
`timescale 1ns/100ps
module pmucr_vmap
    import pmucr_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic [5:0] code,
    output logic [11:0] mv
);
    typedef struct packed {
        logic [11:0] mv;
    } pmucr_vmap_t;

    pmucr_vmap_t st_q;
    pmucr_vmap_t st_d;

    always_comb begin
        st_d.mv = buck_mv(code);
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st_q <= '{mv: 12'h000};
        end else begin
            st_q <= st_d;
        end
    end

    assign mv = st_q.mv;
endmodule

// File: pmucr_checker.sv
// Checker: port-level assertions for the comparator register bank
`timescale 1ns/100ps
module pmucr_checker (
    input wire logic REF_CLK,
    input wire logic RST,
    input wire logic SPI_CS_N,
    input wire logic SPI_DO,
    input wire logic [5:0] BUCK1_CODE,
    input wire logic [5:0] BUCK2_CODE,
    input wire logic COMP_ON,
    input wire logic [5:0] COMP_THR_CODE,
    input wire logic [11:0] COMP_THR_MV,
    input wire logic [6:0] COMP_HYST_MV,
    input wire logic LINEAR_REG_DEEP_SAVE,
    input wire logic [11:0] BUCK1_MV,
    input wire logic [11:0] BUCK2_MV
);
    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge REF_CLK);
    endclocking
    default disable iff (RST);
    // Code and map load from the same core register, so both change in the same cycle
    a_thr_map: assert property ($stable(COMP_THR_CODE) |->
        COMP_THR_MV == 12'(2000 + (32'(COMP_THR_CODE) * 2000 + 31) / 63))
        else $error("threshold millivolts wrong");
    a_comp_rst: assert property ($fell(RST) |-> COMP_ON &&
        COMP_THR_CODE == 6'h19 && COMP_HYST_MV == 7'h28) else $error("comparator reset");
    a_hyst_vals: assert property (COMP_HYST_MV == 7'h28 || COMP_HYST_MV == 7'h50)
        else $error("hysteresis value");
    a_save_rst: assert property ($fell(RST) |-> !LINEAR_REG_DEEP_SAVE)
        else $error("deep save reset");
    a_buck1_map: assert property (!$past(RST) |-> BUCK1_MV ==
        12'(1100 + 50 * (($past(BUCK1_CODE) > 6'h32) ? 6'h32 : $past(BUCK1_CODE))))
        else $error("buck1 millivolts");
    a_buck2_map: assert property (!$past(RST) |-> BUCK2_MV ==
        12'(1100 + 50 * (($past(BUCK2_CODE) > 6'h32) ? 6'h32 : $past(BUCK2_CODE))))
        else $error("buck2 millivolts");
    a_do_idle: assert property (SPI_CS_N |-> !SPI_DO) else $error("data out when idle");
    // Idle link must leave configuration alone once the sync settles
    a_cfg_hold: assert property (SPI_CS_N [*8] |-> $stable(COMP_THR_CODE) &&
        $stable(COMP_ON) && $stable(LINEAR_REG_DEEP_SAVE)) else $error("config moved");
endmodule
bind pmucr_top pmucr_checker pmucr_checker_inst (.REF_CLK(REF_CLK), .RST(RST),
    .SPI_CS_N(SPI_CS_N), .SPI_DO(SPI_DO), .BUCK1_CODE(BUCK1_CODE), .BUCK2_CODE(BUCK2_CODE),
    .COMP_ON(COMP_ON), .COMP_THR_CODE(COMP_THR_CODE), .COMP_THR_MV(COMP_THR_MV),
    .COMP_HYST_MV(COMP_HYST_MV), .LINEAR_REG_DEEP_SAVE(LINEAR_REG_DEEP_SAVE),
    .BUCK1_MV(BUCK1_MV), .BUCK2_MV(BUCK2_MV));

// File: pmucr_host.sv
// Host serial master model, clock runs only inside frames
`timescale 1ns/100ps
module pmucr_host (
    output logic SPI_CLK,
    output logic SPI_CS_N,
    output logic SPI_DI,
    input wire logic SPI_DO
);
    initial begin
        SPI_CLK = 1'b0;
        SPI_CS_N = 1'b1;
        SPI_DI = 1'b0;
    end
    // ----------------------------------------
    // Frame: command, address, data, MSB first
    // ----------------------------------------
    task automatic frame(input logic [1:0] cmd, input logic [4:0] addr, input logic [7:0] wd,
        output logic [7:0] rd, output logic stray);
        logic [14:0] bits;
        bits = {cmd, addr, wd};
        rd = 8'h00;
        stray = 1'b0;
        SPI_CS_N = 1'b0;
        for (int i = 0; i < 15; i++) begin
            SPI_DI = bits[14 - i];
            #6 SPI_CLK = 1'b1;
            #6 SPI_CLK = 1'b0;
            if (i >= 6 && i <= 13) begin
                rd[13 - i] = SPI_DO;
            end else begin
                stray = stray | SPI_DO;
            end
        end
        #6 SPI_CS_N = 1'b1;
        // Released line flips so a stale level is never mistaken for data
        SPI_DI = ~SPI_DI;
        #12;
    endtask
endmodule

// File: test_pmucr_top.sv
// Bench: serial register access, status, interrupt and voltage maps
`timescale 1ns/100ps
module test_pmucr_top;
    import pmucr_pkg::*;
    logic REF_CLK, RST, SPI_CLK, SPI_CS_N, SPI_DI, SPI_DO, COMP_ON, LINEAR_REG_DEEP_SAVE, INT_OUT;
    logic [4:0] pins;
    logic [5:0] b1, b2, COMP_THR_CODE;
    logic [6:0] COMP_HYST_MV;
    logic [11:0] COMP_THR_MV, BUCK1_MV, BUCK2_MV;
    logic [7:0] r;
    logic s;
    logic [5:0] codes [5] = '{6'h00, 6'h26, 6'h32, 6'h33, 6'h3F};
    logic [11:0] mvs [5] = '{12'h44C, 12'hBB8, 12'hE10, 12'hE10, 12'hE10};
    int num_errors = 0;
    int cmp_count = 0;
    pmucr_top pmucr_top_inst (.REF_CLK(REF_CLK), .RST(RST), .SPI_CLK(SPI_CLK),
        .SPI_CS_N(SPI_CS_N), .SPI_DI(SPI_DI), .SPI_DO(SPI_DO), .COMP_OUT(pins[0]),
        .BUCK1_OK(pins[1]), .BUCK2_OK(pins[2]), .BUCK3_OK(pins[3]), .LINEAR_OK(pins[4]),
        .BUCK1_CODE(b1), .BUCK2_CODE(b2), .COMP_ON(COMP_ON), .COMP_THR_CODE(COMP_THR_CODE),
        .COMP_THR_MV(COMP_THR_MV), .COMP_HYST_MV(COMP_HYST_MV),
        .LINEAR_REG_DEEP_SAVE(LINEAR_REG_DEEP_SAVE), .INT_OUT(INT_OUT),
        .BUCK1_MV(BUCK1_MV), .BUCK2_MV(BUCK2_MV));
    pmucr_host pmucr_host_inst (.SPI_CLK(SPI_CLK), .SPI_CS_N(SPI_CS_N), .SPI_DI(SPI_DI),
        .SPI_DO(SPI_DO));
    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic chk(input logic [11:0] got, input logic [11:0] exp);
        cmp_count++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        pmucr_host_inst.frame(CMD_WRITE, a, d, r, s);
        chk({3'h0, s, r}, 12'h000);
        repeat (6) @(posedge REF_CLK);
    endtask
    task automatic rd(input logic [4:0] a, input logic [7:0] e);
        pmucr_host_inst.frame(CMD_READ, a, 8'hA5, r, s);
        chk({3'h0, s, r}, {4'h0, e});
    endtask
    task automatic setp(input logic [4:0] v);
        @(posedge REF_CLK);
        pins <= v;
        repeat (6) @(posedge REF_CLK);
    endtask
    task automatic conclude();
        $display("compares %0d errors %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // ----------------------------------------
    // Clock, watchdog, tests
    // ----------------------------------------
    initial begin
        REF_CLK = 1'b0;
        forever #12.5 REF_CLK = ~REF_CLK;
    end
    initial begin
        #100000;
        num_errors++;
        $display("[FAIL] t=%0t watchdog expired", $time);
        conclude();
    end
    initial begin
        RST = 1'b1;
        pins = 5'h00;
        b1 = 6'h00;
        b2 = 6'h00;
        repeat (5) @(posedge REF_CLK);
        RST <= 1'b0;
        repeat (3) @(posedge REF_CLK);
        chk(COMP_THR_MV, 12'hAEA);
        chk({11'h000, INT_OUT}, 12'h001);
        rd(ADDR_COMP, 8'h33);
        rd(ADDR_IEN, 8'h01);
        rd(ADDR_MISC, 8'h00);
        $display("test reset done");
        wr(ADDR_COMP, 8'hFF);
        chk(COMP_THR_MV, 12'hFA0);
        chk({5'h00, COMP_HYST_MV}, 12'h050);
        chk({5'h00, COMP_ON, COMP_THR_CODE}, 12'h07F);
        wr(ADDR_COMP, 8'h00);
        chk(COMP_THR_MV, 12'h7D0);
        chk({5'h00, COMP_HYST_MV}, 12'h028);
        chk({5'h00, COMP_ON, COMP_THR_CODE}, 12'h000);
        $display("test comparator done");
        wr(ADDR_MISC, 8'hFF);
        rd(ADDR_MISC, 8'h03);
        chk({11'h000, LINEAR_REG_DEEP_SAVE}, 12'h001);
        wr(ADDR_IEN, 8'hE0);
        rd(ADDR_IEN, 8'h00);
        wr(ADDR_STAT, 8'hFF);
        rd(5'h1F, 8'h00);
        pmucr_host_inst.frame(2'h1, ADDR_COMP, 8'hFF, r, s);
        chk({3'h0, s, r}, 12'h000);
        $display("test refusals done");
        setp(5'h1F);
        rd(ADDR_STAT, 8'h1F);
        chk({11'h000, INT_OUT}, 12'h000);
        for (int i = 0; i < 5; i++) begin
            wr(ADDR_IEN, 8'h01 << i);
            setp(~(5'h01 << i));
            chk({11'h000, INT_OUT}, 12'h000);
            setp(5'h01 << i);
            chk({11'h000, INT_OUT}, 12'h001);
            rd(ADDR_STAT, 8'h01 << i);
        end
        wr(ADDR_MISC, 8'h00);
        chk({11'h000, INT_OUT}, 12'h000);
        setp(5'h00);
        chk({11'h000, INT_OUT}, 12'h001);
        $display("test interrupt done");
        for (int i = 0; i < 5; i++) begin
            @(posedge REF_CLK);
            b1 <= codes[i];
            b2 <= codes[4 - i];
            repeat (3) @(posedge REF_CLK);
            chk(BUCK1_MV, mvs[i]);
            chk(BUCK2_MV, mvs[4 - i]);
        end
        $display("test buck map done");
        wr(ADDR_MISC, 8'h02);
        chk({11'h000, LINEAR_REG_DEEP_SAVE}, 12'h001);
        RST <= 1'b1;
        repeat (3) @(posedge REF_CLK);
        RST <= 1'b0;
        repeat (3) @(posedge REF_CLK);
        chk({11'h000, LINEAR_REG_DEEP_SAVE}, 12'h000);
        chk({5'h00, COMP_ON, COMP_THR_CODE}, 12'h059);
        rd(ADDR_MISC, 8'h00);
        $display("test second reset done");
        conclude();
    end
endmodule
